// [boot_ctl_pkg.sv]
// Behaviour
// - After power-up the diagnostic processor fetches from its fixed reset pointer address.
// - Writing one to the select register stalls diagnostics on DMA grant, releases main.
// - Released main processor starts at the address held at its boot vector.
// - Writing zero stalls main on read busy and resumes the diagnostic processor.
// - In maintenance position diagnostics keep control until software writes the select register.
// - Console break with function switch enabled raises an external halt.
// - Backplane halt line assertion raises an external halt; sender holds it long enough.
// - Outside maintenance, DC-OK fall halts only outside protected space with backplane halt enable set.
// - In maintenance mode DC-OK fall halts; enter maintenance or take the action field.
// - Backplane halt lasts 10 ms, DC-OK dip 9 us; probe after 9 ms.
// - Initial test waits for the power good flag before anything else.
// - After stable power check console memory; invalid or zero gets tested and initialised.
// - Loopback alternates 3 s active showing seven and 7 s passive showing four.
// - Loopback error or no characters freezes the LED at seven.
// - Leaving the action position during loopback continues as a normal power-up.
// - Language query with no selection within 30 s defaults to English.
package boot_ctl_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam longint unsigned CLK_HZ = 200_000_000;
   localparam int CNT_W = 40;
   localparam longint unsigned LOOP_ACTIVE_S = 3;
   localparam longint unsigned LOOP_PASSIVE_S = 7;
   localparam longint unsigned LANG_TIMEOUT_S = 30;
   localparam longint unsigned HALT_PROBE_MS = 9;
   localparam longint unsigned BACKPLANE_HALT_LINE_MIN_MS = 10;
   localparam longint unsigned DC_POWER_OK_LINE_DIP_MAX_US = 9;
   localparam logic [CNT_W-1:0] LOOP_ACTIVE_CYC = CNT_W'(LOOP_ACTIVE_S * CLK_HZ);
   localparam logic [CNT_W-1:0] LOOP_PASSIVE_CYC = CNT_W'(LOOP_PASSIVE_S * CLK_HZ);
   localparam logic [CNT_W-1:0] LANG_TIMEOUT_CYC = CNT_W'(LANG_TIMEOUT_S * CLK_HZ);
   localparam logic [CNT_W-1:0] HALT_PROBE_CYC = CNT_W'((HALT_PROBE_MS * CLK_HZ) / 1000);
   localparam int DIP_W = 12;
   localparam logic [DIP_W-1:0] DC_POWER_OK_LINE_DIP_CYC = DIP_W'((DC_POWER_OK_LINE_DIP_MAX_US * CLK_HZ) / 1_000_000);
   // ----------------------------------------------------------------
   // Vectors, display and switch codes
   // ----------------------------------------------------------------
   localparam logic [31:0] DIAG_RESET_PTR = 32'h2004_0000;
   localparam logic [31:0] MAIN_BOOT_VEC = 32'h1FC0_0000;
   localparam logic [3:0] LED_ACTIVE = 4'h7;
   localparam logic [3:0] LED_PASSIVE = 4'h4;
   localparam logic [3:0] LED_ERROR = 4'h7;
   localparam logic [3:0] LED_IDLE = 4'h0;
   localparam logic [3:0] LANG_ENGLISH = 4'h5;
   localparam logic [1:0] OPSW_NORMAL = 2'h0;
   localparam logic [1:0] OPSW_MAINT = 2'h1;
   localparam logic [1:0] OPSW_ACTION = 2'h2;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] IRQ_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] MASK_OFS = 8'h0C;
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_BHENB_BIT = 1;
   localparam int CTRL_HALTEN_BIT = 2;
   localparam int CTRL_ACT_LSB = 3;
   localparam int STAT_POK_BIT = 0;
   localparam int STAT_MAIN_BIT = 1;
   localparam int STAT_NVINIT_BIT = 2;
   localparam int STAT_LED_LSB = 8;
   localparam int STAT_LANG_LSB = 12;
   localparam int STAT_ST_LSB = 16;
   localparam int IRQ_W = 7;
   localparam int EV_BREAK = 0;
   localparam int EV_BACKPLANE_HALT_LINE = 1;
   localparam int EV_DC_POWER_OK_LINE = 2;
   localparam int EV_REPEAT = 3;
   localparam int EV_LOOPERR = 4;
   localparam int EV_LANGTO = 5;
   localparam int EV_LONGDIP = 6;
   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_PWR = 9'h001,
      ST_NVCHK = 9'h002,
      ST_NVINIT = 9'h004,
      ST_DISP = 9'h008,
      ST_LACT = 9'h010,
      ST_LPAS = 9'h020,
      ST_LERR = 9'h040,
      ST_LANG = 9'h080,
      ST_READY = 9'h100
   } seq_state_t;
endpackage

// [dual_cpu_halt_boot_control.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_cpu_halt_boot_control #(
   parameter logic [boot_ctl_pkg::CNT_W-1:0] LOOP_ACTIVE_CYCLES = boot_ctl_pkg::LOOP_ACTIVE_CYC,
   parameter logic [boot_ctl_pkg::CNT_W-1:0] LOOP_PASSIVE_CYCLES = boot_ctl_pkg::LOOP_PASSIVE_CYC,
   parameter logic [boot_ctl_pkg::CNT_W-1:0] LANG_TIMEOUT_CYCLES = boot_ctl_pkg::LANG_TIMEOUT_CYC,
   parameter logic [boot_ctl_pkg::CNT_W-1:0] HALT_PROBE_CYCLES = boot_ctl_pkg::HALT_PROBE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [boot_ctl_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic power_good_flag_in,
   input wire logic nvram_valid_in,
   input wire logic nvram_zero_in,
   input wire logic nvram_init_done_in,
   input wire logic [1:0] op_switch_in,
   input wire logic func_enable_in,
   input wire logic console_break_in,
   input wire logic backplane_halt_line_in,
   input wire logic dc_power_ok_line_in,
   input wire logic halt_protected_in,
   input wire logic loop_error_in,
   input wire logic rx_char_in,
   input wire logic lang_valid_in,
   input wire logic [3:0] lang_code_in,
   output logic [31:0] diag_fetch_addr_out,
   output logic [31:0] main_boot_vector_addr_out,
   output logic diag_run_out,
   output logic diag_dma_stall_out,
   output logic main_run_out,
   output logic read_busy_stall_out,
   output logic nvram_init_out,
   output logic halt_req_out,
   output logic halt_enter_maint_out,
   output logic halt_action_valid_out,
   output logic [1:0] halt_action_out,
   output logic [3:0] led_out,
   output logic [3:0] lang_out,
   output logic irq_out
);
   import boot_ctl_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      seq_state_t st;
      logic sel;
      logic bh_enb;
      logic halts_en;
      logic [1:0] act;
      logic [IRQ_W-1:0] irq;
      logic [IRQ_W-1:0] mask;
      logic [31:0] prdata;
      logic slverr;
      logic [3:0] led;
      logic [3:0] lang;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] probe;
      logic probing;
      logic [DIP_W-1:0] dip;
      logic dc_power_ok_line_prev;
      logic backplane_halt_line_prev;
      logic rx_seen;
      logic nv_bad;
      logic nv_init;
      logic halt_req;
      logic halt_maint;
      logic act_valid;
      logic [1:0] act_out;
   } state_t;

   localparam state_t RESET_STATE = '{st: ST_PWR, dc_power_ok_line_prev: 1'b1, default: '0};

   state_t q;
   state_t d;

   logic setup;
   logic wr;
   logic rd;
   logic mapped;
   logic in_maint;
   logic brk_halt;
   logic bh_halt;
   logic dc_power_ok_line_fall;
   logic dc_halt;
   logic any_halt;
   logic [IRQ_W-1:0] ev;

   always_comb begin
      setup = psel_in && !penable_in;
      wr = psel_in && penable_in && pwrite_in;
      rd = psel_in && penable_in && !pwrite_in;
      mapped = (paddr_in == CTRL_OFS) || (paddr_in == STAT_OFS) ||
               (paddr_in == IRQ_OFS) || (paddr_in == MASK_OFS);
      in_maint = !q.sel;
      brk_halt = console_break_in && func_enable_in;
      bh_halt = backplane_halt_line_in && !q.backplane_halt_line_prev;
      dc_power_ok_line_fall = !dc_power_ok_line_in && q.dc_power_ok_line_prev;
      dc_halt = dc_power_ok_line_fall && (in_maint || (!halt_protected_in && q.bh_enb));
      any_halt = brk_halt || bh_halt || dc_halt;
      ev = '0;
      d = q;
      d.halt_req = 1'b0;
      d.halt_maint = 1'b0;
      d.act_valid = 1'b0;
      d.dc_power_ok_line_prev = dc_power_ok_line_in;
      d.backplane_halt_line_prev = backplane_halt_line_in;

      // ----------------------------------------------------------------
      // APB slave: read data is captured in setup so it is steady in access
      // ----------------------------------------------------------------
      if (setup) begin
         d.slverr = !mapped;
         d.prdata = '0;
         unique case (paddr_in)
            CTRL_OFS: begin
               d.prdata[CTRL_SEL_BIT] = q.sel;
               d.prdata[CTRL_BHENB_BIT] = q.bh_enb;
               d.prdata[CTRL_HALTEN_BIT] = q.halts_en;
               d.prdata[CTRL_ACT_LSB +: 2] = q.act;
            end
            STAT_OFS: begin
               d.prdata[STAT_POK_BIT] = power_good_flag_in;
               d.prdata[STAT_MAIN_BIT] = q.sel;
               d.prdata[STAT_NVINIT_BIT] = q.nv_init;
               d.prdata[STAT_LED_LSB +: 4] = q.led;
               d.prdata[STAT_LANG_LSB +: 4] = q.lang;
               d.prdata[STAT_ST_LSB +: 9] = q.st;
            end
            IRQ_OFS: d.prdata[IRQ_W-1:0] = q.irq;
            MASK_OFS: d.prdata[IRQ_W-1:0] = q.mask;
            default: d.prdata = '0;
         endcase
      end
      if (wr && paddr_in == CTRL_OFS) begin
         d.sel = pwdata_in[CTRL_SEL_BIT];
         d.bh_enb = pwdata_in[CTRL_BHENB_BIT];
         d.halts_en = pwdata_in[CTRL_HALTEN_BIT];
         d.act = pwdata_in[CTRL_ACT_LSB +: 2];
      end
      if (wr && paddr_in == MASK_OFS) begin
         d.mask = pwdata_in[IRQ_W-1:0];
      end

      // ----------------------------------------------------------------
      // Halt sources
      // ----------------------------------------------------------------
      ev[EV_BREAK] = brk_halt;
      ev[EV_BACKPLANE_HALT_LINE] = bh_halt;
      ev[EV_DC_POWER_OK_LINE] = dc_halt;
      if (any_halt) begin
         d.halt_req = 1'b1;
         if (q.halts_en) begin
            d.halt_maint = 1'b1;
         end else begin
            d.act_valid = 1'b1;
            d.act_out = q.act;
         end
         // A DC-OK dip is gone long before the probe ends; a line still high is a backplane halt
         d.probing = 1'b1;
         d.probe = '0;
      end else if (q.probing) begin
         if (q.probe == HALT_PROBE_CYCLES - 1'b1) begin
            d.probing = 1'b0;
            ev[EV_REPEAT] = backplane_halt_line_in;
         end else begin
            d.probe = q.probe + 1'b1;
         end
      end
      // Dips beyond the allowed width are reported, not filtered
      if (dc_power_ok_line_in) begin
         d.dip = '0;
      end else if (q.dip != DC_POWER_OK_LINE_DIP_CYC) begin
         d.dip = q.dip + 1'b1;
         ev[EV_LONGDIP] = (q.dip == DC_POWER_OK_LINE_DIP_CYC - 1'b1);
      end

      // ----------------------------------------------------------------
      // Power-up sequencer
      // ----------------------------------------------------------------
      unique case (q.st)
         ST_PWR: begin
            if (power_good_flag_in) begin
               d.st = ST_NVCHK;
            end
         end
         ST_NVCHK: begin
            if (!nvram_valid_in || nvram_zero_in) begin
               d.st = ST_NVINIT;
               d.nv_init = 1'b1;
               d.nv_bad = 1'b1;
            end else begin
               d.st = ST_DISP;
            end
         end
         ST_NVINIT: begin
            if (nvram_init_done_in) begin
               d.nv_init = 1'b0;
               d.st = ST_DISP;
            end
         end
         ST_DISP: begin
            d.cnt = '0;
            if (op_switch_in == OPSW_ACTION && func_enable_in) begin
               d.st = ST_LACT;
               d.led = LED_ACTIVE;
               d.rx_seen = 1'b0;
            end else if ((op_switch_in == OPSW_ACTION) || (q.nv_bad && op_switch_in == OPSW_NORMAL)) begin
               d.st = ST_LANG;
               d.led = LED_IDLE;
            end else begin
               d.st = ST_READY;
               d.led = LED_IDLE;
            end
         end
         ST_LACT: begin
            d.rx_seen = q.rx_seen || rx_char_in;
            if (op_switch_in != OPSW_ACTION) begin
               d.st = ST_DISP;
            end else if (loop_error_in) begin
               d.st = ST_LERR;
               d.led = LED_ERROR;
               ev[EV_LOOPERR] = 1'b1;
            end else if (q.cnt == LOOP_ACTIVE_CYCLES - 1'b1) begin
               d.cnt = '0;
               if (!(q.rx_seen || rx_char_in)) begin
                  d.st = ST_LERR;
                  d.led = LED_ERROR;
                  ev[EV_LOOPERR] = 1'b1;
               end else begin
                  d.st = ST_LPAS;
                  d.led = LED_PASSIVE;
               end
            end else begin
               d.cnt = q.cnt + 1'b1;
            end
         end
         ST_LPAS: begin
            if (op_switch_in != OPSW_ACTION) begin
               d.st = ST_DISP;
            end else if (q.cnt == LOOP_PASSIVE_CYCLES - 1'b1) begin
               d.cnt = '0;
               d.st = ST_LACT;
               d.led = LED_ACTIVE;
               d.rx_seen = 1'b0;
            end else begin
               d.cnt = q.cnt + 1'b1;
            end
         end
         ST_LERR: begin
            // Frozen display; only the switch gets the board out of here
            if (op_switch_in != OPSW_ACTION) begin
               d.st = ST_DISP;
            end
         end
         ST_LANG: begin
            if (lang_valid_in) begin
               d.lang = lang_code_in;
               d.st = ST_READY;
            end else if (q.cnt == LANG_TIMEOUT_CYCLES - 1'b1) begin
               d.lang = LANG_ENGLISH;
               d.st = ST_READY;
               ev[EV_LANGTO] = 1'b1;
            end else begin
               d.cnt = q.cnt + 1'b1;
            end
         end
         ST_READY: begin
            d.cnt = '0;
         end
         default: d.st = ST_PWR;
      endcase

      // Read clears status, but an event in the same cycle is kept
      if (rd && paddr_in == IRQ_OFS) begin
         d.irq = '0;
      end
      d.irq = d.irq | ev;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_out = q.prdata;
   assign pready_out = 1'b1;
   assign pslverr_out = q.slverr;
   assign diag_fetch_addr_out = DIAG_RESET_PTR;
   assign main_boot_vector_addr_out = MAIN_BOOT_VEC;
   // One select flop drives both sides so there is no cycle with both running
   assign main_run_out = q.sel;
   assign diag_run_out = !q.sel;
   assign diag_dma_stall_out = q.sel;
   assign read_busy_stall_out = !q.sel;
   assign nvram_init_out = q.nv_init;
   assign halt_req_out = q.halt_req;
   assign halt_enter_maint_out = q.halt_maint;
   assign halt_action_valid_out = q.act_valid;
   assign halt_action_out = q.act_out;
   assign led_out = q.led;
   assign lang_out = q.lang;
   assign irq_out = |(q.irq & q.mask);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence ctrl_write;
      wr && paddr_in == CTRL_OFS;
   endsequence

   sequence loop_active_end;
      q.st == ST_LACT && op_switch_in == OPSW_ACTION && !loop_error_in &&
         q.cnt == LOOP_ACTIVE_CYCLES - 1'b1 && (q.rx_seen || rx_char_in);
   endsequence

   a_select_one_release: assert property (ctrl_write and pwdata_in[CTRL_SEL_BIT] |=>
      main_run_out && diag_dma_stall_out && !diag_run_out)
      else $error("select one did not release main processor");
   a_select_zero_resume: assert property (ctrl_write and !pwdata_in[CTRL_SEL_BIT] |=>
      diag_run_out && read_busy_stall_out && !main_run_out)
      else $error("select zero did not resume diagnostics");
   a_select_holds: assert property (!(wr && paddr_in == CTRL_OFS) |=> $stable(main_run_out))
      else $error("processor select changed without a write");
   a_exclusive_run: assert property (main_run_out != diag_run_out)
      else $error("processors not mutually exclusive");
   a_power_wait: assert property (q.st == ST_PWR && !power_good_flag_in |=> q.st == ST_PWR)
      else $error("sequencer left power wait early");
   a_nvram_init: assert property (q.st == ST_NVCHK && (!nvram_valid_in || nvram_zero_in) |=>
      nvram_init_out && q.st == ST_NVINIT)
      else $error("bad console memory not initialised");
   a_loop_phase: assert property (loop_active_end |=> led_out == LED_PASSIVE && q.st == ST_LPAS)
      else $error("loopback did not enter passive phase");
   a_loop_led: assert property (q.st == ST_LACT |-> led_out == LED_ACTIVE)
      else $error("active phase LED wrong");
   a_loop_freeze: assert property (q.st == ST_LACT && op_switch_in == OPSW_ACTION && loop_error_in |=>
      q.st == ST_LERR ##1 led_out == LED_ERROR)
      else $error("loopback error did not freeze display");
   a_loop_exit: assert property ((q.st == ST_LACT || q.st == ST_LPAS || q.st == ST_LERR) &&
      op_switch_in != OPSW_ACTION |=> q.st == ST_DISP)
      else $error("switch move did not resume power-up");
   a_lang_default: assert property (q.st == ST_LANG && !lang_valid_in &&
      q.cnt == LANG_TIMEOUT_CYCLES - 1'b1 |=> lang_out == LANG_ENGLISH && q.st == ST_READY)
      else $error("language timeout did not default");
   a_break_halt: assert property (console_break_in && func_enable_in |=> halt_req_out)
      else $error("console break halt missing");
   a_backplane_halt_line_halt: assert property ($rose(backplane_halt_line_in) |=> halt_req_out)
      else $error("backplane halt missing");
   a_dc_power_ok_line_gate: assert property (dc_power_ok_line_fall && !in_maint && halt_protected_in && !brk_halt && !bh_halt |=>
      !halt_req_out)
      else $error("halt delivered in protected space");
   a_maint_dc_power_ok_line: assert property (dc_power_ok_line_fall && in_maint && q.halts_en |=> halt_enter_maint_out)
      else $error("maintenance DC-OK halt not taken");
   a_probe_repeat: assert property (q.probing && !any_halt && q.probe == HALT_PROBE_CYCLES - 1'b1 &&
      backplane_halt_line_in |=> q.irq[EV_REPEAT])
      else $error("repeated halt not classed as backplane");
endmodule
`default_nettype wire

// [dual_cpu_halt_boot_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_cpu_halt_boot_control_bench;
   import boot_ctl_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk, rst_n, psel, pen, pwr, pg, nv_ok, nv_done, fen, prot, echo, bh, dc_power_ok_line, brk, rxc, err;
   logic pready, pslverr, drun, dstall, mrun, rbusy, nvinit, hreq, hmaint, hvalid, irq, gm, gv;
   logic zero, lerr, lv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, dvec, mvec, m;
   logic [1:0] opsw, hact, ga;
   logic [3:0] led, lang, lc;
   int num_errors = 0;
   int n_compared = 0;
   int seed = 32'hd821;
   int n, got;
   halt_source_model halt_source_model_inst (.clk_in(clk), .echo_in(echo), .backplane_halt_line_out(bh),
      .dc_power_ok_line_out(dc_power_ok_line), .console_break_out(brk), .rx_char_out(rxc));
   dual_cpu_halt_boot_control #(.LOOP_ACTIVE_CYCLES(40'h1E), .LOOP_PASSIVE_CYCLES(40'h46),
      .LANG_TIMEOUT_CYCLES(40'h64), .HALT_PROBE_CYCLES(40'h14)) dual_cpu_halt_boot_control_inst (
      .clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .power_good_flag_in(pg), .nvram_valid_in(nv_ok), .nvram_zero_in(zero), .nvram_init_done_in(nv_done),
      .op_switch_in(opsw), .func_enable_in(fen), .console_break_in(brk), .backplane_halt_line_in(bh),
      .dc_power_ok_line_in(dc_power_ok_line), .halt_protected_in(prot), .loop_error_in(lerr), .rx_char_in(rxc),
      .lang_valid_in(lv), .lang_code_in(lc), .diag_fetch_addr_out(dvec), .main_boot_vector_addr_out(mvec),
      .diag_run_out(drun), .diag_dma_stall_out(dstall), .main_run_out(mrun), .read_busy_stall_out(rbusy),
      .nvram_init_out(nvinit), .halt_req_out(hreq), .halt_enter_maint_out(hmaint),
      .halt_action_valid_out(hvalid), .halt_action_out(hact), .led_out(led), .lang_out(lang), .irq_out(irq));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Wide enough for a status flag packed above a full data word
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic fire(input int k);
      case (k)
         0: halt_source_model_inst.send_break();
         1: halt_source_model_inst.raise_halt(30);
         default: halt_source_model_inst.dip_power(5);
      endcase
   endtask
   // Halt pulses last one cycle, so the watcher runs beside the cause
   task automatic trigger(input int k);
      got = 0;
      fork
         fire(k);
         repeat (8) begin
            @(negedge clk);
            if (hreq === 1'b1) begin
               got = 1;
               gm = hmaint;
               gv = hvalid;
               ga = hact;
            end
         end
      join
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog, sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      num_errors++;
      give_verdict();
   end
   initial begin
      {rst_n, psel, pen, pwr, pg, nv_ok, nv_done, prot, echo, zero, lerr, lv, lc} = '0;
      fen = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      opsw = OPSW_NORMAL;
      do_reset();
      check({drun, mrun}, 2'b10);
      check(dvec, DIAG_RESET_PTR);
      check(mvec, MAIN_BOOT_VEC);
      repeat (10) @(posedge clk);
      apb(1'b0, STAT_OFS, 32'h0);
      check({nvinit, rd[24:16]}, 10'h001);
      pg <= 1'b1;
      for (n = 0; n < 20 && nvinit !== 1'b1; n++) @(negedge clk);
      check(nvinit, 1'b1);
      @(posedge clk);
      nv_done <= 1'b1;
      for (n = 0; n < 300 && lang === 4'h0; n++) @(negedge clk);
      check({lang, 1'(n >= 100)}, {LANG_ENGLISH, 1'b1});
      m = $random(seed);
      apb(1'b1, MASK_OFS, m);
      apb(1'b0, MASK_OFS, 32'h0);
      check(rd, m & 32'h7F);
      check(irq, m[EV_LANGTO]);
      apb(1'b0, IRQ_OFS, 32'h0);
      check(rd, 32'h20);
      apb(1'b0, IRQ_OFS, 32'h0);
      check({rd, irq}, 33'h0);
      apb(1'b1, CTRL_OFS, 32'h1);
      @(negedge clk);
      check({mrun, dstall, drun, rbusy}, 4'hC);
      apb(1'b1, CTRL_OFS, 32'h0);
      @(negedge clk);
      check({mrun, dstall, drun, rbusy}, 4'h3);
      apb(1'b0, 8'h10, 32'h0);
      check({err, rd}, 33'h100000000);
      apb(1'b1, CTRL_OFS, 32'h4);
      for (int k = 0; k < 3; k++) begin
         trigger(k);
         repeat (30) @(posedge clk);
         check({got[0], gm}, 2'h3);
         apb(1'b0, IRQ_OFS, 32'h0);
         check(rd, (k == 1) ? 32'hA : (32'h1 << k));
      end
      for (int a = 0; a < 4; a++) begin
         apb(1'b1, CTRL_OFS, 32'(a) << CTRL_ACT_LSB);
         trigger(0);
         check({got[0], gm, gv, ga}, {3'h5, 2'(a)});
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         prot <= (i == 0);
         apb(1'b1, CTRL_OFS, (i == 2) ? 32'h1 : 32'h3);
         trigger(2);
         check(got, (i == 1));
      end
      opsw <= OPSW_ACTION;
      nv_ok <= 1'b1;
      echo <= 1'b1;
      do_reset();
      for (n = 0; n < 50 && led !== LED_ACTIVE; n++) @(negedge clk);
      for (n = 0; led === LED_ACTIVE; n++) @(negedge clk);
      check(n, 30);
      @(posedge clk);
      echo <= 1'b0;
      for (n = 0; led === LED_PASSIVE; n++) @(negedge clk);
      check(n, 70);
      repeat (150) @(negedge clk);
      apb(1'b0, STAT_OFS, 32'h0);
      check({led, rd[24:16]}, {LED_ERROR, 9'h040});
      opsw <= OPSW_MAINT;
      repeat (5) @(posedge clk);
      apb(1'b0, STAT_OFS, 32'h0);
      check({mrun, rd[24:16]}, 10'h100);
      // Zeroed console memory, then a parity-type error in the first active phase
      opsw <= OPSW_ACTION;
      zero <= 1'b1;
      do_reset();
      for (n = 0; n < 50 && led !== LED_ACTIVE; n++) @(negedge clk);
      @(posedge clk);
      lerr <= 1'b1;
      @(posedge clk);
      lerr <= 1'b0;
      apb(1'b0, IRQ_OFS, 32'h0);
      check({led, rd}, {LED_ERROR, 32'h10});
      // Leaving action with bad memory ends in the query; a break is ignored with the function switch disabled
      opsw <= OPSW_NORMAL;
      fen <= 1'b0;
      trigger(0);
      check(got, 0);
      @(posedge clk);
      lc <= 4'($random(seed));
      lv <= 1'b1;
      @(posedge clk);
      lv <= 1'b0;
      apb(1'b0, STAT_OFS, 32'h0);
      check({lang, rd[24:16]}, {lc, 9'h100});
      give_verdict();
   end
endmodule
`default_nettype wire

// [halt_source_model.sv]
`timescale 1ns/1ps
`default_nettype none
module halt_source_model (
   input wire logic clk_in,
   input wire logic echo_in,
   output logic backplane_halt_line_out,
   output logic dc_power_ok_line_out,
   output logic console_break_out,
   output logic rx_char_out
);
   // ------------------------------------------------------------
   // Line drivers
   // ------------------------------------------------------------
   logic [1:0] tick_q;
   initial begin
      tick_q = 2'h0;
      rx_char_out = 1'b0;
      backplane_halt_line_out = 1'b0;
      dc_power_ok_line_out = 1'b1;
      console_break_out = 1'b0;
   end
   // Looped-back characters come every fourth cycle, so each active phase sees several
   always @(posedge clk_in) begin
      tick_q <= tick_q + 2'h1;
      rx_char_out <= echo_in && (tick_q == 2'h0);
   end
   // Held past the probe window so the repeated halt finds the line still high
   task automatic raise_halt(input int hold);
      @(posedge clk_in);
      backplane_halt_line_out <= 1'b1;
      repeat (hold) @(posedge clk_in);
      backplane_halt_line_out <= 1'b0;
   endtask
   // Dip stays far below the longest allowed dip
   task automatic dip_power(input int len);
      @(posedge clk_in);
      dc_power_ok_line_out <= 1'b0;
      repeat (len) @(posedge clk_in);
      dc_power_ok_line_out <= 1'b1;
   endtask
   task automatic send_break();
      @(posedge clk_in);
      console_break_out <= 1'b1;
      @(posedge clk_in);
      console_break_out <= 1'b0;
   endtask
endmodule
`default_nettype wire
